// *** hdl/pho_params.svh ***
`ifndef PHO_PARAMS_SVH
`define PHO_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PHO_OFS_LDCFG 8'h18
`define PHO_OFS_LDPIN 8'h1A
`define PHO_OFS_MONSEL 8'h1B
`define PHO_OFS_REFCTL 8'h1C
`define PHO_OFS_HOCTL 8'h1D
`define PHO_OFS_CHIGN 8'h1E
`define PHO_OFS_STAT 8'h1F

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define PHO_REFBUF_LSB 1
`define PHO_REFBUF_MSB 2
`define PHO_LDPIN_DLD 6'h00
`define PHO_LDPIN_CSRC 6'h04
`define PHO_MONSEL_FIRST_N 8'hF7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PHO_RST_LDCFG 8'h00
`define PHO_RST_LDPIN 8'h00
`define PHO_RST_MONSEL 8'h00
`define PHO_RST_REFCTL 8'h00
`define PHO_RST_HOCTL 8'h00
`define PHO_RST_CHIGN 8'h00

// ----------------------------------------------------------------------------
// Lock detect counts (detector cycles) and thresholds
// ----------------------------------------------------------------------------
`define PHO_LD_CNT_00 5
`define PHO_LD_CNT_01 16
`define PHO_LD_CNT_10 64
`define PHO_LD_CNT_11 255
`define PHO_LOCK_THR_LO 8'h04
`define PHO_LOCK_THR_HI 8'h08
`define PHO_UNLOCK_THR_LO 8'h08
`define PHO_UNLOCK_THR_HI 8'h10

`endif

// *** hdl/pho_pkg.sv ***
`default_nettype none

package pho_pkg;

  typedef enum logic [1:0] {
    PHO_RUN = 2'h0,
    PHO_HOLD = 2'h1,
    PHO_REARM = 2'h3
  } pho_state_type;

  // Lock detect configuration, laid out as bits 6:3 of its register.
  typedef struct packed {
    logic [1:0] count_sel;
    logic window_hi_n;
    logic dld_off;
  } pho_ldcfg_type;

  // Holdover control, laid out as bits 3:0 of its register.
  typedef struct packed {
    logic cmp_en;
    logic en_hi;
    logic ext_sel;
    logic en_lo;
  } pho_hoctl_type;

endpackage : pho_pkg

`default_nettype wire

// *** hdl/pho_lock_detect.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pho_params.svh"

module pho_lock_detect
  import pho_pkg::*;
#(
  parameter int ERR_W = 8,
  parameter logic [7:0] CNT_00 = 8'(`PHO_LD_CNT_00),
  parameter logic [7:0] CNT_01 = 8'(`PHO_LD_CNT_01),
  parameter logic [7:0] CNT_10 = 8'(`PHO_LD_CNT_10),
  parameter logic [7:0] CNT_11 = 8'(`PHO_LD_CNT_11)
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Configuration
  input wire pho_ldcfg_type cfg_i,
  // Detector cycle and edge time difference
  input wire logic pfd_cycle_i,
  input wire logic [ERR_W-1:0] phase_err_i,
  // Lock indication
  output logic locked_o
);

  logic [7:0] good_cnt_ff;
  logic locked_ff;
  logic [7:0] need;
  logic [ERR_W-1:0] lock_thr;
  logic [ERR_W-1:0] unlock_thr;

  always_comb begin
    case (cfg_i.count_sel)
      2'h0: need = CNT_00;
      2'h1: need = CNT_01;
      2'h2: need = CNT_10;
      default: need = CNT_11;
    endcase
  end

  // A cleared window bit selects the high range.
  assign lock_thr = cfg_i.window_hi_n ? ERR_W'(`PHO_LOCK_THR_LO) : ERR_W'(`PHO_LOCK_THR_HI);
  assign unlock_thr = cfg_i.window_hi_n ? ERR_W'(`PHO_UNLOCK_THR_LO) :
                      ERR_W'(`PHO_UNLOCK_THR_HI);

  always_ff @(posedge mclk_i) begin
    if (srst_i || cfg_i.dld_off) begin
      good_cnt_ff <= 8'h00;
      locked_ff <= 1'b0;
    end else if (pfd_cycle_i) begin
      if (locked_ff) begin
        if (phase_err_i > unlock_thr) begin
          locked_ff <= 1'b0;
          good_cnt_ff <= 8'h00;
        end
      end else if (phase_err_i < lock_thr) begin
        if (good_cnt_ff + 8'h01 >= need) begin
          locked_ff <= 1'b1;
        end
        good_cnt_ff <= good_cnt_ff + 8'h01;
      end else begin
        good_cnt_ff <= 8'h00;
      end
    end
  end

  assign locked_o = locked_ff;

  property p_unlock_single;
    @(posedge mclk_i) disable iff (srst_i)
      (locked_ff && pfd_cycle_i && !cfg_i.dld_off && phase_err_i > unlock_thr) |=> !locked_ff;
  endproperty
  a_unlock_single: assert property (p_unlock_single) else $error("Lock kept after bad cycle.");

  property p_lock_needs_count;
    @(posedge mclk_i) disable iff (srst_i)
      $rose(locked_ff) |-> $past(good_cnt_ff) + 8'h01 >= $past(need);
  endproperty
  a_lock_needs_count: assert property (p_lock_needs_count) else $error("Lock too early.");

endmodule : pho_lock_detect
`default_nettype wire

// *** hdl/pho_holdover.sv ***
// Behaviour
// - Holdover parks charge pump in high impedance.
// - Both enable bits required for any holdover.
// - Manual hold pin falling edge enters holdover.
// - Release on next reference detector edge (with manual control, once the pin is high again), or at once when an enable bit clears.
// - Reset B counter at release on a reference edge (not when an enable bit clears), prescaler runs.
// - Non-ignoring channels turn off while pin low.
// - Automatic holdover enters on sensed loss of lock.
// - Comparator disabled means lock pin reads high.
// - Re-entry waits for relock and recharged pin.
// - Holdover follows selected reference, releases on edge.
// - Lock count field, 00b means five cycles.
// - External control bit cleared selects automatic holdover.
// - Select 000100b routes current-source lock detect.
// - Window bit cleared selects high range.
// - Reference control 11b enables both buffers.
// - Monitor select 0xF7 gives first reference, low-active.
// - Digital lock held until one cycle exceeds unlock.
`timescale 1ns/1ns
`default_nettype none
`include "pho_params.svh"

module pho_holdover
  import pho_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int ERR_W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Pins
  input wire logic manual_hold_n_i,
  input wire logic lock_indicator_pin_i,
  output logic lock_indicator_pin_o,
  output logic lock_indicator_pin_oe_o,
  output logic lock_indicator_csrc_o,
  output logic reference_monitor_pin_o,
  // Detector side, same clock domain
  input wire logic ref_pfd_edge_i,
  input wire logic pfd_cycle_i,
  input wire logic [ERR_W-1:0] phase_err_i,
  input wire logic first_reference_ok_i,
  // Loop and distribution controls
  output logic cp_hiz_o,
  output logic b_counter_reset_o,
  output logic [1:0] ref_buf_en_o,
  output logic [CHANNELS-1:0] dist_out_off_o,
  output logic digital_lock_detection_o
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] ldcfg_ff;
  logic [7:0] ldpin_ff;
  logic [7:0] monsel_ff;
  logic [7:0] refctl_ff;
  logic [7:0] hoctl_ff;
  logic [7:0] chign_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  pho_ldcfg_type ldcfg;
  pho_hoctl_type hoctl;

  assign ldcfg = pho_ldcfg_type'(ldcfg_ff[6:3]);
  assign hoctl = pho_hoctl_type'(hoctl_ff[3:0]);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ldcfg_ff <= `PHO_RST_LDCFG;
      ldpin_ff <= `PHO_RST_LDPIN;
      monsel_ff <= `PHO_RST_MONSEL;
      refctl_ff <= `PHO_RST_REFCTL;
      hoctl_ff <= `PHO_RST_HOCTL;
      chign_ff <= `PHO_RST_CHIGN;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PHO_OFS_LDCFG: ldcfg_ff <= reg_wdata_i;
        `PHO_OFS_LDPIN: ldpin_ff <= reg_wdata_i;
        `PHO_OFS_MONSEL: monsel_ff <= reg_wdata_i;
        `PHO_OFS_REFCTL: refctl_ff <= reg_wdata_i;
        `PHO_OFS_HOCTL: hoctl_ff <= reg_wdata_i;
        `PHO_OFS_CHIGN: chign_ff <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // The manual pin gets a third stage so the edge detector never looks at
  // the metastable first flop.
  logic hold_s1_ff;
  logic hold_s2_ff;
  logic hold_s3_ff;
  logic ld_s1_ff;
  logic ld_s2_ff;
  logic hold_fall;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hold_s1_ff <= 1'b1;
      hold_s2_ff <= 1'b1;
      hold_s3_ff <= 1'b1;
    end else begin
      hold_s1_ff <= manual_hold_n_i;
      hold_s2_ff <= hold_s1_ff;
      hold_s3_ff <= hold_s2_ff;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ld_s1_ff <= 1'b0;
      ld_s2_ff <= 1'b0;
    end else begin
      ld_s1_ff <= lock_indicator_pin_i;
      ld_s2_ff <= ld_s1_ff;
    end
  end

  assign hold_fall = hold_s3_ff & ~hold_s2_ff;

  // --------------------------------------------------------------------------
  // Digital lock detection
  // --------------------------------------------------------------------------
  logic digital_lock_detection;

  // Automatic holdover only behaves when the host leaves this enabled.
  pho_lock_detect #(
    .ERR_W(ERR_W)
  ) u_lock_detect (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .cfg_i(ldcfg),
    .pfd_cycle_i(pfd_cycle_i),
    .phase_err_i(phase_err_i),
    .locked_o(digital_lock_detection)
  );

  assign digital_lock_detection_o = digital_lock_detection;

  // --------------------------------------------------------------------------
  // Lock indicator pin drive
  // --------------------------------------------------------------------------
  logic ld_out_ff;
  logic ld_oe_ff;
  logic ld_csrc_ff;

  // In current-source mode the pin is shorted low while unlocked and left
  // to charge its capacitor while locked, so any glitch restarts the charge.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ld_out_ff <= 1'b0;
      ld_oe_ff <= 1'b0;
      ld_csrc_ff <= 1'b0;
    end else if (ldpin_ff[5:0] == `PHO_LDPIN_CSRC) begin
      ld_out_ff <= 1'b0;
      ld_oe_ff <= ~digital_lock_detection;
      ld_csrc_ff <= digital_lock_detection;
    end else if (ldpin_ff[5:0] == `PHO_LDPIN_DLD) begin
      ld_out_ff <= digital_lock_detection;
      ld_oe_ff <= 1'b1;
      ld_csrc_ff <= 1'b0;
    end else begin
      ld_out_ff <= 1'b0;
      ld_oe_ff <= 1'b1;
      ld_csrc_ff <= 1'b0;
    end
  end

  assign lock_indicator_pin_o = ld_out_ff;
  assign lock_indicator_pin_oe_o = ld_oe_ff;
  assign lock_indicator_csrc_o = ld_csrc_ff;

  // --------------------------------------------------------------------------
  // Reference buffers and monitor pin
  // --------------------------------------------------------------------------
  logic mon_pin_ff;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mon_pin_ff <= 1'b0;
    end else if (monsel_ff == `PHO_MONSEL_FIRST_N) begin
      mon_pin_ff <= ~first_reference_ok_i;
    end else begin
      mon_pin_ff <= 1'b0;
    end
  end

  assign reference_monitor_pin_o = mon_pin_ff;
  assign ref_buf_en_o = refctl_ff[`PHO_REFBUF_MSB:`PHO_REFBUF_LSB];

  // --------------------------------------------------------------------------
  // Distribution output gating
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      logic off_ff;
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          off_ff <= 1'b0;
        end else begin
          off_ff <= ~chign_ff[gi] & ~hold_s2_ff;
        end
      end
      assign dist_out_off_o[gi] = off_ff;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Holdover state machine
  // --------------------------------------------------------------------------
  pho_state_type state_ff;
  pho_state_type nxt_state;
  logic ho_en;
  logic lock_sense;
  logic man_trig;
  logic auto_trig;
  logic release_ok;

  assign ho_en = hoctl.en_lo & hoctl.en_hi;
  assign lock_sense = hoctl.cmp_en ? ld_s2_ff : 1'b1;
  assign man_trig = ho_en & hoctl.ext_sel & hold_fall;
  assign auto_trig = ho_en & ~hoctl.ext_sel & ~lock_sense;
  // The edge comes from the selected reference only, so a switchover that
  // loses lock is released by the new reference's first edge.
  assign release_ok = ref_pfd_edge_i & (~hoctl.ext_sel | hold_s2_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PHO_RUN: begin
        if (man_trig || auto_trig) begin
          nxt_state = PHO_HOLD;
        end
      end
      PHO_HOLD: begin
        if (!ho_en) begin
          nxt_state = PHO_RUN;
        end else if (release_ok) begin
          nxt_state = hoctl.ext_sel ? PHO_RUN : PHO_REARM;
        end
      end
      PHO_REARM: begin
        if (!ho_en || hoctl.ext_sel) begin
          nxt_state = man_trig ? PHO_HOLD : PHO_RUN;
        end else if (digital_lock_detection && lock_sense) begin
          nxt_state = PHO_RUN;
        end
      end
      default: nxt_state = PHO_RUN;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_ff <= PHO_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Entry acts in the trigger cycle itself to avoid a pump pulse slipping out.
  assign cp_hiz_o = (state_ff == PHO_HOLD) | (state_ff != PHO_HOLD && nxt_state == PHO_HOLD);
  assign b_counter_reset_o = (state_ff == PHO_HOLD) & ho_en & release_ok;

  // --------------------------------------------------------------------------
  // Read back
  // --------------------------------------------------------------------------
  always_comb begin
    case (reg_addr_i)
      `PHO_OFS_LDCFG: nxt_rdata = ldcfg_ff;
      `PHO_OFS_LDPIN: nxt_rdata = ldpin_ff;
      `PHO_OFS_MONSEL: nxt_rdata = monsel_ff;
      `PHO_OFS_REFCTL: nxt_rdata = refctl_ff;
      `PHO_OFS_HOCTL: nxt_rdata = hoctl_ff;
      `PHO_OFS_CHIGN: nxt_rdata = chign_ff;
      `PHO_OFS_STAT: nxt_rdata = {3'h0, cp_hiz_o, digital_lock_detection, lock_sense, state_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data stand for one cycle only and are zero otherwise.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_ff;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_hold_parks;
    @(posedge mclk_i) disable iff (srst_i)
      (state_ff == PHO_HOLD) |-> cp_hiz_o;
  endproperty
  a_hold_parks: assert property (p_hold_parks) else $error("Pump driven in holdover.");

  property p_disabled_no_hold;
    @(posedge mclk_i) disable iff (srst_i)
      (!ho_en && state_ff != PHO_HOLD) |=> (state_ff != PHO_HOLD);
  endproperty
  a_disabled_no_hold: assert property (p_disabled_no_hold) else $error("Hold while off.");

  property p_manual_entry;
    @(posedge mclk_i) disable iff (srst_i)
      (ho_en && hoctl.ext_sel && $fell(hold_s2_ff)) |-> cp_hiz_o ##1 (state_ff == PHO_HOLD);
  endproperty
  a_manual_entry: assert property (p_manual_entry) else $error("Manual edge missed.");

  property p_level_no_retrigger;
    @(posedge mclk_i) disable iff (srst_i)
      (state_ff == PHO_RUN && hoctl.ext_sel && !hold_fall) |=> (state_ff == PHO_RUN);
  endproperty
  a_level_no_retrigger: assert property (p_level_no_retrigger) else $error("Level retrigger.");

  property p_wait_edge;
    @(posedge mclk_i) disable iff (srst_i)
      (state_ff == PHO_HOLD && ho_en && !ref_pfd_edge_i) |=> (state_ff == PHO_HOLD);
  endproperty
  a_wait_edge: assert property (p_wait_edge) else $error("Release without edge.");

  property p_b_reset;
    @(posedge mclk_i) disable iff (srst_i)
      b_counter_reset_o |-> ref_pfd_edge_i ##1 (state_ff != PHO_HOLD);
  endproperty
  a_b_reset: assert property (p_b_reset) else $error("B reset not at release.");

  property p_dist_off;
    @(posedge mclk_i) disable iff (srst_i)
      (!hold_s2_ff && !chign_ff[0]) |=> dist_out_off_o[0];
  endproperty
  a_dist_off: assert property (p_dist_off) else $error("Channel not turned off.");

  property p_auto_entry;
    @(posedge mclk_i) disable iff (srst_i)
      (state_ff == PHO_RUN && ho_en && !hoctl.ext_sel && hoctl.cmp_en && !ld_s2_ff)
        |=> (state_ff == PHO_HOLD);
  endproperty
  a_auto_entry: assert property (p_auto_entry) else $error("Loss of lock ignored.");

  property p_cmp_off;
    @(posedge mclk_i) disable iff (srst_i)
      (state_ff == PHO_RUN && !hoctl.cmp_en && !hoctl.ext_sel) |=> (state_ff == PHO_RUN);
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("Comparator off yet held.");

  property p_rearm_wait;
    @(posedge mclk_i) disable iff (srst_i)
      (state_ff == PHO_REARM && !digital_lock_detection) |=> (state_ff != PHO_HOLD);
  endproperty
  a_rearm_wait: assert property (p_rearm_wait) else $error("Re-entry before relock.");

  property p_mon_pin;
    @(posedge mclk_i) disable iff (srst_i)
      (monsel_ff == `PHO_MONSEL_FIRST_N) ##1 (monsel_ff == `PHO_MONSEL_FIRST_N)
        |-> reference_monitor_pin_o == !$past(first_reference_ok_i);
  endproperty
  a_mon_pin: assert property (p_mon_pin) else $error("Monitor pin wrong.");

endmodule : pho_holdover
`default_nettype wire

// *** bench/pho_ref_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module pho_ref_model #(
  parameter int PER = 8,
  parameter int CHG = 20
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Bench controls
  input wire logic ref_on_i,
  input wire logic [7:0] err_i,
  // Lock pin drive from the block
  input wire logic pin_o_i,
  input wire logic pin_oe_i,
  input wire logic csrc_i,
  // Detector events and sensed pin level
  output logic ref_pfd_edge_o,
  output logic pfd_cycle_o,
  output logic [7:0] phase_err_o,
  output logic pin_level_o
);
  int div_ff;
  int chg_ff;

  // A lost reference stops dead, so no detector edge arrives at all.
  always_ff @(posedge mclk_i) begin
    if (srst_i || !ref_on_i) begin
      div_ff <= 0;
      pfd_cycle_o <= 1'b0;
    end else begin
      div_ff <= (div_ff == PER - 1) ? 0 : div_ff + 1;
      pfd_cycle_o <= (div_ff == PER - 1);
    end
  end

  assign ref_pfd_edge_o = pfd_cycle_o;
  // Outside a detector cycle the difference is garbage, not the last value.
  assign phase_err_o = pfd_cycle_o ? err_i : ~err_i;

  // The capacitor charges only from the current source and drains at once otherwise.
  always_ff @(posedge mclk_i) begin
    if (srst_i || pin_oe_i || !csrc_i) begin
      chg_ff <= 0;
    end else if (chg_ff < CHG) begin
      chg_ff <= chg_ff + 1;
    end
  end

  assign pin_level_o = pin_oe_i ? pin_o_i : (chg_ff >= CHG);

endmodule : pho_ref_model
`default_nettype wire

// *** bench/tb_pho_holdover.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pho_params.svh"

module tb_pho_holdover
  import pho_pkg::*;
;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic manual_hold_n = 1'b1;
  logic first_ref_ok = 1'b1;
  logic ref_on = 1'b0;
  logic [7:0] err = 8'h06;
  logic [7:0] reg_rdata, phase_err;
  logic pin_level, pin_out, pin_oe, csrc, mon_pin, ref_edge, pfd_cycle, cp_hiz, b_reset, digital_lock_detection;
  logic [1:0] ref_buf_en;
  logic [3:0] dist_off;
  int fails = 0;
  int cmp_count = 0;

  always #25 mclk_i = ~mclk_i;

  pho_holdover #(.CHANNELS(4), .ERR_W(8)) u_dut (
    .mclk_i(mclk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .manual_hold_n_i(manual_hold_n),
    .lock_indicator_pin_i(pin_level), .lock_indicator_pin_o(pin_out),
    .lock_indicator_pin_oe_o(pin_oe), .lock_indicator_csrc_o(csrc),
    .reference_monitor_pin_o(mon_pin), .ref_pfd_edge_i(ref_edge), .pfd_cycle_i(pfd_cycle),
    .phase_err_i(phase_err), .first_reference_ok_i(first_ref_ok), .cp_hiz_o(cp_hiz),
    .b_counter_reset_o(b_reset), .ref_buf_en_o(ref_buf_en), .dist_out_off_o(dist_off),
    .digital_lock_detection_o(digital_lock_detection)
  );

  pho_ref_model #(.PER(8), .CHG(20)) u_far (
    .mclk_i(mclk_i), .srst_i(srst_i), .ref_on_i(ref_on), .err_i(err),
    .pin_o_i(pin_out), .pin_oe_i(pin_oe), .csrc_i(csrc),
    .ref_pfd_edge_o(ref_edge), .pfd_cycle_o(pfd_cycle), .phase_err_o(phase_err),
    .pin_level_o(pin_level)
  );

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task automatic pfd_wait(input int n);
    repeat (n) begin
      do @(posedge mclk_i); while (pfd_cycle !== 1'b1);
    end
  endtask : pfd_wait

  task automatic set_pin(input logic v);
    @(posedge mclk_i);
    manual_hold_n <= v;
  endtask : set_pin

  task automatic wait_hiz(input logic exp, input int max, input string msg);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (cp_hiz !== exp && n < max);
    chk(8'(cp_hiz), 8'(exp), msg);
  endtask : wait_hiz

  // Also flags any counter reset pulse, which must not appear while nothing is released.
  task automatic hold_hiz(input logic exp, input int cycles, input string msg);
    int bad;
    bad = 0;
    repeat (cycles) begin
      cyc(1);
      if (cp_hiz !== exp || b_reset !== 1'b0) bad++;
    end
    chk(8'(bad), 8'h00, msg);
  endtask : hold_hiz

  task automatic release_chk();
    int n;
    int seen;
    n = 0;
    seen = 0;
    @(posedge mclk_i);
    ref_on <= 1'b1;
    do begin
      cyc(1);
      n++;
      if (b_reset === 1'b1 && cp_hiz === 1'b1) seen++;
    end while (cp_hiz !== 1'b0 && n < 20);
    chk(8'(seen), 8'h01, "one counter reset at release");
    chk(8'(cp_hiz), 8'h00, "no release on reference edge");
  endtask : release_chk

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] ofs [6] = '{`PHO_OFS_LDCFG, `PHO_OFS_LDPIN, `PHO_OFS_MONSEL,
                            `PHO_OFS_REFCTL, `PHO_OFS_HOCTL, `PHO_OFS_CHIGN};
    foreach (ofs[i]) begin
      rd(ofs[i], d);
      chk(d, 8'h00, "register reset value");
    end
    wr(8'h20, 8'h5A);
    rd(8'h20, d);
    chk(d, 8'h00, "unmapped read not zero");
    wr(`PHO_OFS_REFCTL, 8'h06);
    rd(`PHO_OFS_REFCTL, d);
    chk(d, 8'h06, "reference control readback");
    chk(8'(ref_buf_en), 8'h03, "reference buffers not both on");
    wr(`PHO_OFS_MONSEL, `PHO_MONSEL_FIRST_N);
    first_ref_ok <= 1'b0;
    cyc(3);
    chk(8'(mon_pin), 8'h01, "monitor pin not low-active");
    @(posedge mclk_i);
    first_ref_ok <= 1'b1;
    cyc(3);
    chk(8'(mon_pin), 8'h00, "monitor pin stuck");
  endtask : t_regs

  task automatic t_enable();
    logic [7:0] cfg [2] = '{8'h03, 8'h06};
    foreach (cfg[i]) begin
      wr(`PHO_OFS_HOCTL, cfg[i]);
      set_pin(1'b0);
      hold_hiz(1'b0, 8, "holdover with one enable bit");
      set_pin(1'b1);
      cyc(4);
    end
  endtask : t_enable

  task automatic t_manual();
    logic [7:0] d;
    wr(`PHO_OFS_CHIGN, 8'h05);
    wr(`PHO_OFS_HOCTL, 8'h07);
    set_pin(1'b0);
    wait_hiz(1'b1, 4, "pin fall did not park pump");
    hold_hiz(1'b1, 10, "pump left park while pin low");
    chk(8'(dist_off), 8'h0A, "channel off mask wrong");
    rd(`PHO_OFS_STAT, d);
    chk(d, 8'h15, "status wrong in holdover");
    set_pin(1'b1);
    hold_hiz(1'b1, 20, "release without reference edge");
    chk(8'(dist_off), 8'h00, "channels stay off");
    release_chk();
    hold_hiz(1'b0, 24, "retrigger without new fall");
    wr(`PHO_OFS_HOCTL, 8'h00);
    @(posedge mclk_i);
    ref_on <= 1'b0;
  endtask : t_manual

  task automatic t_lock();
    wr(`PHO_OFS_LDCFG, 8'h08);
    wr(`PHO_OFS_LDCFG, 8'h00);
    wr(`PHO_OFS_LDPIN, {2'h0, `PHO_LDPIN_CSRC});
    @(posedge mclk_i);
    ref_on <= 1'b1;
    pfd_wait(4);
    cyc(3);
    chk(8'(digital_lock_detection), 8'h00, "lock after four cycles");
    pfd_wait(1);
    cyc(3);
    chk(8'(digital_lock_detection), 8'h01, "no lock after five cycles");
    chk(8'(csrc), 8'h01, "current source not routed");
    chk(8'(pin_oe), 8'h00, "lock pin shorted while locked");
    wr(`PHO_OFS_LDPIN, 8'h00);
    cyc(2);
    chk({6'h0, pin_oe, pin_out}, 8'h03, "lock pin not driving lock state");
    wr(`PHO_OFS_LDPIN, {2'h0, `PHO_LDPIN_CSRC});
    err <= 8'h0C;
    pfd_wait(3);
    cyc(3);
    chk(8'(digital_lock_detection), 8'h01, "lock lost inside unlock threshold");
    err <= 8'h14;
    pfd_wait(1);
    err <= 8'h06;
    cyc(3);
    chk(8'(digital_lock_detection), 8'h00, "lock kept beyond unlock threshold");
    wr(`PHO_OFS_LDCFG, 8'h08);
    pfd_wait(6);
    cyc(2);
    chk(8'(digital_lock_detection), 8'h00, "lock reported while disabled");
    wr(`PHO_OFS_LDCFG, 8'h10);
    pfd_wait(6);
    cyc(2);
    chk(8'(digital_lock_detection), 8'h00, "lock outside low-range window");
    ref_on <= 1'b0;
  endtask : t_lock

  task automatic t_auto();
    int n;
    int bad;
    n = 0;
    bad = 0;
    wr(`PHO_OFS_LDCFG, 8'h00);
    wr(`PHO_OFS_HOCTL, 8'h05);
    hold_hiz(1'b0, 10, "sense low with comparator off");
    wr(`PHO_OFS_HOCTL, 8'h0D);
    wait_hiz(1'b1, 6, "no automatic entry on lost lock");
    hold_hiz(1'b1, 12, "release without reference");
    release_chk();
    while (!(digital_lock_detection === 1'b1 && pin_level === 1'b1) && n < 300) begin
      cyc(1);
      n++;
      if (cp_hiz !== 1'b0) bad++;
    end
    chk(8'(pin_level), 8'h01, "pin never charged");
    hold_hiz(1'b0, 10, "re-entry while rearming");
    chk(8'(bad), 8'h00, "re-entry before relock");
    err <= 8'h14;
    pfd_wait(1);
    err <= 8'h06;
    wait_hiz(1'b1, 10, "no re-entry on later loss");
    wr(`PHO_OFS_HOCTL, 8'h00);
    ref_on <= 1'b0;
  endtask : t_auto

  // ---------------------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_regs();
    t_enable();
    t_manual();
    t_lock();
    t_auto();
    finish_test();
  end

  // The whole sequence takes well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    finish_test();
  end

endmodule : tb_pho_holdover
`default_nettype wire
